// File: tcc_pkg.sv
// constants, field layouts and carrier types of the 8-bit timer/counter
// assumes one clock domain and an AXI4-Lite master with 32-bit data
package tcc_pkg;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] TCC_OFF_CTRL_A = 8'h00;
	localparam logic [7:0] TCC_OFF_CTRL_B = 8'h04;
	localparam logic [7:0] TCC_OFF_COUNT = 8'h08;
	localparam logic [7:0] TCC_OFF_CMP_A = 8'h0c;
	localparam logic [7:0] TCC_OFF_CMP_B = 8'h10;
	localparam logic [7:0] TCC_OFF_MASK = 8'h14;
	localparam logic [7:0] TCC_OFF_FLAG = 8'h18;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int TCC_CA_COM_A_POS = 6;
	localparam int TCC_CA_COM_B_POS = 4;
	localparam int TCC_CA_WGM_LO_POS = 0;
	localparam int TCC_CB_FOC_A_POS = 7;
	localparam int TCC_CB_FOC_B_POS = 6;
	localparam int TCC_CB_WGM_HI_POS = 3;
	localparam int TCC_CB_CS_POS = 0;

	// ************************************************************
	// values
	// ************************************************************
	localparam logic [7:0] TCC_BOTTOM = 8'h00;
	localparam logic [7:0] TCC_MAX = 8'hff;
	localparam logic [7:0] TCC_BYTE_RST = 8'h00;
	localparam logic [2:0] TCC_CS_OFF = 3'h0;
	localparam logic [2:0] TCC_CS_DIV1 = 3'h1;
	localparam logic [2:0] TCC_CS_DIV8 = 3'h2;
	localparam logic [2:0] TCC_CS_DIV64 = 3'h3;
	localparam logic [2:0] TCC_CS_DIV256 = 3'h4;
	localparam logic [2:0] TCC_CS_DIV1024 = 3'h5;
	localparam logic [2:0] TCC_CS_EXT_FALL = 3'h6;
	localparam logic [2:0] TCC_CS_EXT_RISE = 3'h7;
	localparam logic [2:0] TCC_WGM_NORMAL = 3'h0;
	localparam logic [2:0] TCC_WGM_CTC = 3'h2;
	localparam logic [2:0] TCC_WGM_FAST_CMPA = 3'h7;
	localparam logic [1:0] TCC_LO_PC = 2'h1;
	localparam logic [1:0] TCC_LO_FAST = 2'h3;
	localparam logic [1:0] TCC_COM_NONE = 2'h0;
	localparam logic [1:0] TCC_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TCC_COM_CLEAR = 2'h2;
	localparam logic [1:0] TCC_COM_SET = 2'h3;
	localparam int TCC_PRE_W = 10;
	localparam logic [9:0] TCC_PRE_M8 = 10'h007;
	localparam logic [9:0] TCC_PRE_M64 = 10'h03f;
	localparam logic [9:0] TCC_PRE_M256 = 10'h0ff;
	localparam logic [9:0] TCC_PRE_M1024 = 10'h3ff;
	localparam logic [1:0] TCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] TCC_RESP_SLVERR = 2'h2;

	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed {
		logic [1:0] com_a;
		logic [1:0] com_b;
		logic [2:0] wgm;
		logic [2:0] cs;
	} tcc_ctrl_t;

	typedef struct packed {
		logic ocf_b;
		logic ocf_a;
		logic tov;
	} tcc_flags_t;

	localparam tcc_ctrl_t TCC_CTRL_RST = '{2'h0, 2'h0, 3'h0, 3'h0};
	localparam tcc_flags_t TCC_FLAGS_RST = '{1'b0, 1'b0, 1'b0};

	typedef enum logic [1:0] {
		TCC_DIR_UP = 2'b01,
		TCC_DIR_DOWN = 2'b10
	} tcc_dir_t;

endpackage : tcc_pkg

// File: tcc_timer.sv
// 8-bit timer/counter with two compare units behind an AXI4-Lite slave
// assumes mclk_i at 125 MHz, synchronous reset, count pin synchronous
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
module tcc_timer (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic ext_count_i,
	input wire tcc_pkg::tcc_flags_t int_ack_i,
	output tcc_pkg::tcc_flags_t irq_o,
	output logic compare_output_a_o,
	output logic compare_output_b_o
);
	import tcc_pkg::*;

	// ************************************************************
	// bus slave state
	// ************************************************************
	logic aw_hold_reg, aw_hold_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic w_hold_reg, w_hold_next;
	logic [7:0] wdata_reg, wdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	// ************************************************************
	// timer state
	// ************************************************************
	tcc_ctrl_t ctrl_reg, ctrl_next;
	tcc_flags_t flags_reg, flags_next;
	tcc_flags_t mask_reg, mask_next;
	tcc_dir_t dir_reg, dir_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [7:0] ocra_reg, ocra_next;
	logic [7:0] ocrb_reg, ocrb_next;
	logic [7:0] bufa_reg, bufa_next;
	logic [7:0] bufb_reg, bufb_next;
	logic block_reg, block_next;
	logic oca_reg, oca_next;
	logic ocb_reg, ocb_next;
	logic ext_prev_reg;
	logic [TCC_PRE_W-1:0] pre_reg;

	logic wr_go, wr_ok, wr_ctrl_a, wr_ctrl_b, wr_count, wr_cmp_a, wr_cmp_b;
	logic wr_mask, wr_flag, addr_ok_w, addr_ok_r;
	logic tick, is_pwm, is_fast, is_pc, match_a, match_b;
	logic [7:0] top;
	logic [7:0] rd_val;

	// ************************************************************
	// write decode
	// ************************************************************
	assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_ok = wr_go && wstrb0_reg;
	assign wr_ctrl_a = wr_ok && (awaddr_reg == TCC_OFF_CTRL_A);
	assign wr_ctrl_b = wr_ok && (awaddr_reg == TCC_OFF_CTRL_B);
	assign wr_count = wr_ok && (awaddr_reg == TCC_OFF_COUNT);
	assign wr_cmp_a = wr_ok && (awaddr_reg == TCC_OFF_CMP_A);
	assign wr_cmp_b = wr_ok && (awaddr_reg == TCC_OFF_CMP_B);
	assign wr_mask = wr_ok && (awaddr_reg == TCC_OFF_MASK);
	assign wr_flag = wr_ok && (awaddr_reg == TCC_OFF_FLAG);
	assign addr_ok_w = (awaddr_reg <= TCC_OFF_FLAG) &&
		(awaddr_reg[1:0] == 2'h0);
	assign addr_ok_r = (s_axi_araddr_i <= TCC_OFF_FLAG) &&
		(s_axi_araddr_i[1:0] == 2'h0);

	// ************************************************************
	// tick select and mode decode
	// ************************************************************
	always_comb begin
		unique case (ctrl_reg.cs)
			TCC_CS_OFF: tick = 1'b0;
			TCC_CS_DIV1: tick = 1'b1;
			TCC_CS_DIV8: tick = (pre_reg[2:0] == TCC_PRE_M8[2:0]);
			TCC_CS_DIV64: tick = (pre_reg[5:0] == TCC_PRE_M64[5:0]);
			TCC_CS_DIV256: tick = (pre_reg[7:0] == TCC_PRE_M256[7:0]);
			TCC_CS_DIV1024: tick = (pre_reg == TCC_PRE_M1024);
			TCC_CS_EXT_FALL: tick = ext_prev_reg && !ext_count_i;
			TCC_CS_EXT_RISE: tick = !ext_prev_reg && ext_count_i;
		endcase
	end

	assign is_pwm = ctrl_reg.wgm[0];
	assign is_fast = (ctrl_reg.wgm[1:0] == TCC_LO_FAST);
	assign is_pc = (ctrl_reg.wgm[1:0] == TCC_LO_PC);
	assign top = ctrl_reg.wgm[2] ? ocra_reg : TCC_MAX;
	// matches are dropped for the tick after a count write
	assign match_a = tick && !block_reg && !wr_count &&
		(cnt_reg == ocra_reg);
	assign match_b = tick && !block_reg && !wr_count &&
		(cnt_reg == ocrb_reg);

	// ************************************************************
	// next output compare state
	// ************************************************************
	function automatic logic tcc_next_oc(input logic cur,
		input logic [1:0] com, input logic pwm, input logic fast,
		input logic long_top, input logic hit, input logic bottom,
		input logic down, input logic chan_a);
		logic r;
		r = cur;
		if (com == TCC_COM_NONE) begin
			r = cur;
		end else if (!pwm) begin
			if (hit) begin
				r = (com == TCC_COM_TOGGLE) ? ~cur : (com == TCC_COM_SET);
			end
		end else if (com == TCC_COM_TOGGLE) begin
			if (hit && chan_a && long_top) begin
				r = ~cur;
			end
		end else if (fast) begin
			if (hit) begin
				r = (com == TCC_COM_SET);
			end else if (bottom) begin
				r = (com == TCC_COM_CLEAR);
			end
		end else if (hit) begin
			r = (com == TCC_COM_CLEAR) ? down : ~down;
		end
		return r;
	endfunction : tcc_next_oc

	// ************************************************************
	// timer next state
	// ************************************************************
	always_comb begin : timer_next
		logic wrap;
		logic tov_evt;
		logic load_buf;
		logic force_a;
		logic force_b;
		logic [2:0] clr;
		wrap = 1'b0;
		tov_evt = 1'b0;
		load_buf = 1'b0;
		clr = 3'h0;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		dir_next = dir_reg;
		cnt_next = cnt_reg;
		ocra_next = ocra_reg;
		ocrb_next = ocrb_reg;
		bufa_next = bufa_reg;
		bufb_next = bufb_reg;
		block_next = block_reg;
		force_a = wr_ctrl_b && wdata_reg[TCC_CB_FOC_A_POS] && !is_pwm;
		force_b = wr_ctrl_b && wdata_reg[TCC_CB_FOC_B_POS] && !is_pwm;
		if (wr_ctrl_a) begin
			ctrl_next.com_a = wdata_reg[TCC_CA_COM_A_POS +: 2];
			ctrl_next.com_b = wdata_reg[TCC_CA_COM_B_POS +: 2];
			ctrl_next.wgm[1:0] = wdata_reg[TCC_CA_WGM_LO_POS +: 2];
		end
		if (wr_ctrl_b) begin
			ctrl_next.wgm[2] = wdata_reg[TCC_CB_WGM_HI_POS];
			ctrl_next.cs = wdata_reg[TCC_CB_CS_POS +: 3];
		end
		if (wr_mask) begin
			mask_next = wdata_reg[2:0];
		end
		if (wr_cmp_a) begin
			bufa_next = wdata_reg;
			if (!is_pwm) begin
				ocra_next = wdata_reg;
			end
		end
		if (wr_cmp_b) begin
			bufb_next = wdata_reg;
			if (!is_pwm) begin
				ocrb_next = wdata_reg;
			end
		end
		if (wr_count) begin
			cnt_next = wdata_reg;
			block_next = 1'b1;
		end else if (tick) begin
			block_next = 1'b0;
			if (is_fast) begin
				if (cnt_reg == top) begin
					cnt_next = TCC_BOTTOM;
					wrap = 1'b1;
					tov_evt = 1'b1;
					load_buf = 1'b1;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end else if (is_pc) begin
				unique case (dir_reg)
					TCC_DIR_UP: begin
						if (cnt_reg == top) begin
							dir_next = TCC_DIR_DOWN;
							cnt_next = cnt_reg - 8'h01;
							load_buf = 1'b1;
						end else begin
							cnt_next = cnt_reg + 8'h01;
						end
					end
					TCC_DIR_DOWN: begin
						if (cnt_reg == TCC_BOTTOM) begin
							dir_next = TCC_DIR_UP;
							cnt_next = cnt_reg + 8'h01;
							tov_evt = 1'b1;
						end else begin
							cnt_next = cnt_reg - 8'h01;
						end
					end
				endcase
			end else begin
				if (ctrl_reg.wgm == TCC_WGM_CTC && cnt_reg == ocra_reg) begin
					cnt_next = TCC_BOTTOM;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
				tov_evt = (cnt_reg == TCC_MAX);
			end
		end
		if (!is_pc) begin
			dir_next = TCC_DIR_UP;
		end
		if (load_buf) begin
			ocra_next = bufa_reg;
			ocrb_next = bufb_reg;
		end
		// output state is never reset by a mode change
		oca_next = tcc_next_oc(oca_reg, ctrl_reg.com_a, is_pwm, is_fast,
			ctrl_reg.wgm[2], match_a || force_a, wrap,
			dir_reg == TCC_DIR_DOWN, 1'b1);
		ocb_next = tcc_next_oc(ocb_reg, ctrl_reg.com_b, is_pwm, is_fast,
			ctrl_reg.wgm[2], match_b || force_b, wrap,
			dir_reg == TCC_DIR_DOWN, 1'b0);
		// write-one or service clears; a new event wins over the clear
		clr = (wr_flag ? wdata_reg[2:0] : 3'h0) | int_ack_i;
		flags_next = (flags_reg & ~clr) |
			{match_b, match_a, tov_evt};
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ctrl_reg <= TCC_CTRL_RST;
			flags_reg <= TCC_FLAGS_RST;
			mask_reg <= TCC_FLAGS_RST;
			dir_reg <= TCC_DIR_UP;
			cnt_reg <= TCC_BYTE_RST;
			ocra_reg <= TCC_BYTE_RST;
			ocrb_reg <= TCC_BYTE_RST;
			bufa_reg <= TCC_BYTE_RST;
			bufb_reg <= TCC_BYTE_RST;
			block_reg <= 1'b0;
			oca_reg <= 1'b0;
			ocb_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			pre_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			flags_reg <= flags_next;
			mask_reg <= mask_next;
			dir_reg <= dir_next;
			cnt_reg <= cnt_next;
			ocra_reg <= ocra_next;
			ocrb_reg <= ocrb_next;
			bufa_reg <= bufa_next;
			bufb_reg <= bufb_next;
			block_reg <= block_next;
			oca_reg <= oca_next;
			ocb_reg <= ocb_next;
			ext_prev_reg <= ext_count_i;
			pre_reg <= pre_reg + 10'h001;
		end
	end

	assign irq_o = flags_reg & mask_reg;
	assign compare_output_a_o = oca_reg;
	assign compare_output_b_o = ocb_reg;

	// ************************************************************
	// bus slave
	// ************************************************************
	always_comb begin
		unique case (s_axi_araddr_i)
			TCC_OFF_CTRL_A: rd_val = {ctrl_reg.com_a, ctrl_reg.com_b, 2'h0,
				ctrl_reg.wgm[1:0]};
			TCC_OFF_CTRL_B: rd_val = {4'h0, ctrl_reg.wgm[2], ctrl_reg.cs};
			TCC_OFF_COUNT: rd_val = cnt_reg;
			TCC_OFF_CMP_A: rd_val = bufa_reg;
			TCC_OFF_CMP_B: rd_val = bufb_reg;
			TCC_OFF_MASK: rd_val = {5'h00, mask_reg};
			TCC_OFF_FLAG: rd_val = {5'h00, flags_reg};
			default: rd_val = 8'h00;
		endcase
	end

	always_comb begin : bus_next
		aw_hold_next = aw_hold_reg;
		awaddr_next = awaddr_reg;
		w_hold_next = w_hold_reg;
		wdata_next = wdata_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_awvalid_i && !aw_hold_reg) begin
			aw_hold_next = 1'b1;
			awaddr_next = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !w_hold_reg) begin
			w_hold_next = 1'b1;
			wdata_next = s_axi_wdata_i[7:0];
			wstrb0_next = s_axi_wstrb_i[0];
		end
		if (wr_go) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = addr_ok_w ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready_i) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid_i && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rdata_next = {24'h000000, rd_val};
			rresp_next = addr_ok_r ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready_i) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			w_hold_reg <= 1'b0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= TCC_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= TCC_RESP_OKAY;
		end else begin
			aw_hold_reg <= aw_hold_next;
			awaddr_reg <= awaddr_next;
			w_hold_reg <= w_hold_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_awready_o = !aw_hold_reg;
	assign s_axi_wready_o = !w_hold_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = !rvalid_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	sequence s_ctc_hit;
		tick && !wr_count && ctrl_reg.wgm == TCC_WGM_CTC &&
			cnt_reg == ocra_reg;
	endsequence
	sequence s_normal_wrap;
		tick && !wr_count && ctrl_reg.wgm == TCC_WGM_NORMAL &&
			cnt_reg == TCC_MAX;
	endsequence
	sequence s_force_toggle_a;
		wr_ctrl_b && wdata_reg[TCC_CB_FOC_A_POS] && !is_pwm &&
			ctrl_reg.com_a == TCC_COM_TOGGLE && !wr_ctrl_a;
	endsequence

	AST_STOPPED: assert property (
		ctrl_reg.cs == TCC_CS_OFF && !wr_count |=> $stable(cnt_reg))
		else $error("count moved while stopped");
	AST_WRITE_WINS: assert property (
		wr_count |=> cnt_reg == $past(wdata_reg))
		else $error("count write lost");
	AST_NORMAL_WRAP: assert property (
		s_normal_wrap |=> cnt_reg == TCC_BOTTOM && flags_reg.tov)
		else $error("normal wrap wrong");
	AST_CTC_CLEAR: assert property (
		s_ctc_hit |=> cnt_reg == TCC_BOTTOM)
		else $error("ctc did not clear");
	AST_MATCH_FLAG: assert property (
		tick && !block_reg && !wr_count && cnt_reg == ocrb_reg
		|=> flags_reg.ocf_b) else $error("compare b flag not set");
	AST_BLOCK: assert property (
		block_reg && tick && !flags_reg.ocf_a |=> !flags_reg.ocf_a)
		else $error("blocked match set flag");
	AST_FORCE: assert property (
		s_force_toggle_a ##0 (!flags_reg.ocf_a && !match_a)
		|=> compare_output_a_o != $past(compare_output_a_o) &&
		!flags_reg.ocf_a) else $error("force compare wrong");
	AST_CLEAR_ONE: assert property (
		wr_flag && wdata_reg[1] && !match_a |=> !flags_reg.ocf_a)
		else $error("flag not cleared");
	AST_ZERO_KEEP: assert property (
		wr_flag && !wdata_reg[0] && flags_reg.tov && !int_ack_i.tov
		|=> flags_reg.tov) else $error("zero write cleared flag");
	AST_BUFFERED: assert property (
		is_pwm && wr_cmp_a && tick == 1'b0
		|=> ocra_reg == $past(ocra_reg)) else $error("buffer bypassed");
	AST_IRQ: assert property (
		s_normal_wrap ##0 (mask_reg.tov && !wr_mask) |=> irq_o.tov)
		else $error("interrupt not raised");

endmodule : tcc_timer

// File: tcc_pin_model.sv
// pin-side model: drives the count pin and counts changes of output a
// assumes the bench calls pulse() from its clocked sequence
module tcc_pin_model (
	input wire logic mclk_i,
	input wire logic compare_output_a_i,
	output logic ext_count_o,
	output int toggle_count_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// count pin and output watch
	// ************************************************************
	initial begin
		ext_count_o = 1'b0;
		toggle_count_o = 0;
	end

	always @(compare_output_a_i) begin
		toggle_count_o++;
	end

	// each level held at least three clocks (high three, low four between pulses) so the synchronous sampler sees it
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			ext_count_o <= 1'b1;
			repeat (3) @(posedge mclk_i);
			ext_count_o <= 1'b0;
			repeat (3) @(posedge mclk_i);
		end
	endtask : pulse

endmodule : tcc_pin_model

// File: tcc_timer_bench.sv
// self-checking bench for the timer/counter through its register bus
// assumes the pin model drives the count pin and watches output a
module tcc_timer_bench;
	import tcc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// signals
	// ************************************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic br = 1'b0;
	logic arv = 1'b0;
	logic rr = 1'b0;
	logic awr, wrd, bv, arr, rv, pin, oa, ob;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdat, v;
	tcc_flags_t ack = TCC_FLAGS_RST;
	tcc_flags_t irq;
	int tog;
	int bad_count = 0;
	int num_checks = 0;
	int lo[5] = '{16, 129, 15, 3, 0};
	int hi[5] = '{22, 132, 17, 5, 2};

	tcc_timer u_tcc_timer (
		.mclk_i(clk),
		.reset_i(rst),
		.s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr),
		.s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'h1),
		.s_axi_wvalid_i(wv),
		.s_axi_wready_o(wrd),
		.s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bv),
		.s_axi_bready_i(br),
		.s_axi_araddr_i(ara),
		.s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr),
		.s_axi_rdata_o(rdat),
		.s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rv),
		.s_axi_rready_i(rr),
		.ext_count_i(pin),
		.int_ack_i(ack),
		.irq_o(irq),
		.compare_output_a_o(oa),
		.compare_output_b_o(ob)
	);

	tcc_pin_model u_tcc_pin_model (
		.mclk_i(clk),
		.compare_output_a_i(oa),
		.ext_count_o(pin),
		.toggle_count_o(tog)
	);

	// ************************************************************
	// bus and check tasks
	// ************************************************************
	task automatic check(input string nm, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, d);
		int n = 0;
		@(posedge clk);
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while (bv !== 1'b1 && n < 100);
		br <= 1'b0;
		check("bvalid", {31'h0, bv}, 32'h1);
		check("bresp", {30'h0, bresp}, {30'h0, TCC_RESP_OKAY});
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] q);
		int n = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arv && arr) arv <= 1'b0;
		end while (rv !== 1'b1 && n < 100);
		d = rdat;
		q = rresp;
		check("rvalid", {31'h0, rv}, 32'h1);
		rr <= 1'b0;
	endtask : rd

	task automatic rc(input logic [7:0] a, e, input string nm);
		rd(a, v, r);
		check(nm, v, {24'h0, e});
	endtask : rc

	task automatic report_and_stop;
		if (bad_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// ************************************************************
	// clock, watchdog and tests
	// ************************************************************
	initial begin
		forever #4 clk = ~clk;
	end

	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end

	initial begin
		int n0;
		logic s;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rc(TCC_OFF_CTRL_A, 8'h00, "ctrl_a");
		rc(TCC_OFF_COUNT, TCC_BOTTOM, "count");
		rc(TCC_OFF_FLAG, 8'h00, "flags");
		check("oc", {30'h0, oa, ob}, 32'h0);
		rd(8'h1c, v, r);
		check("slverr", {30'h0, r}, {30'h0, TCC_RESP_SLVERR});
		check("bad_rd", v, 32'h0);
		// stopped timer keeps a written count
		wr(TCC_OFF_COUNT, 8'h80);
		repeat (20) @(posedge clk);
		rc(TCC_OFF_COUNT, 8'h80, "count_stop");
		// output state set up by force before use
		wr(TCC_OFF_CTRL_A, {2'h0, TCC_COM_SET, 4'h0});
		wr(TCC_OFF_CTRL_B, 8'h40);
		check("force_b", {31'h0, ob}, 32'h1);
		rc(TCC_OFF_FLAG, 8'h00, "force_flag");
		rc(TCC_OFF_COUNT, 8'h80, "force_cnt");
		// compare equal to count: first tick must not match
		wr(TCC_OFF_CMP_B, 8'h80);
		wr(TCC_OFF_CTRL_B, {5'h0, TCC_CS_DIV1});
		repeat (8) @(posedge clk);
		wr(TCC_OFF_CTRL_B, 8'h00);
		rc(TCC_OFF_FLAG, 8'h00, "blocked");
		// wrap through zero: overflow and compare a at zero
		wr(TCC_OFF_COUNT, 8'hf8);
		wr(TCC_OFF_MASK, 8'h01);
		wr(TCC_OFF_CTRL_B, {5'h0, TCC_CS_DIV1});
		repeat (16) @(posedge clk);
		wr(TCC_OFF_CTRL_B, 8'h00);
		rc(TCC_OFF_FLAG, 8'h03, "ovf");
		check("irq", {29'h0, irq}, 32'h1);
		wr(TCC_OFF_FLAG, 8'h00);
		rc(TCC_OFF_FLAG, 8'h03, "w0");
		wr(TCC_OFF_FLAG, 8'h01);
		rc(TCC_OFF_FLAG, 8'h02, "w1");
		check("irq_clr", {29'h0, irq}, 32'h0);
		@(posedge clk);
		ack <= '{1'b0, 1'b1, 1'b0};
		@(posedge clk);
		ack <= TCC_FLAGS_RST;
		rc(TCC_OFF_FLAG, 8'h00, "ack");
		// clear on compare a with toggling output
		wr(TCC_OFF_CTRL_A, {TCC_COM_TOGGLE, 4'h0, TCC_WGM_CTC[1:0]});
		wr(TCC_OFF_CMP_A, 8'h09);
		wr(TCC_OFF_COUNT, 8'h00);
		n0 = tog;
		wr(TCC_OFF_CTRL_B, {5'h0, TCC_CS_DIV1});
		repeat (100) @(posedge clk);
		wr(TCC_OFF_CTRL_B, 8'h00);
		check("ctc_tog", {31'h0, (tog - n0) inside {[9:12]}}, 32'h1);
		rd(TCC_OFF_COUNT, v, r);
		check("ctc_top", {31'h0, v < 32'h0a}, 32'h1);
		wr(TCC_OFF_FLAG, 8'h07);
		s = oa;
		wr(TCC_OFF_CTRL_B, 8'h80);
		check("force_a", {31'h0, oa}, {31'h0, ~s});
		rc(TCC_OFF_FLAG, 8'h00, "force_a_flag");
		s = oa;
		wr(TCC_OFF_CTRL_A, {TCC_COM_TOGGLE, 4'h0, TCC_LO_FAST});
		check("keep_oc", {31'h0, oa}, {31'h0, s});
		// pwm: compare a write stays in the buffer until top
		wr(TCC_OFF_CMP_A, 8'h05);
		rc(TCC_OFF_CMP_A, 8'h05, "buf_rd");
		wr(TCC_OFF_COUNT, 8'h04);
		wr(TCC_OFF_CTRL_B, {5'h0, TCC_CS_EXT_RISE});
		u_tcc_pin_model.pulse(2);
		wr(TCC_OFF_CTRL_B, 8'h00);
		rc(TCC_OFF_FLAG, 8'h00, "buffered");
		// fast pwm with top from compare a, then phase correct
		wr(TCC_OFF_CTRL_B, {4'h0, 1'b1, TCC_CS_DIV1});
		repeat (20) @(posedge clk);
		wr(TCC_OFF_CTRL_B, 8'h08);
		rc(TCC_OFF_FLAG, 8'h03, "fast_top");
		rd(TCC_OFF_COUNT, v, r);
		check("fast_cnt", {31'h0, v < 32'h06}, 32'h1);
		wr(TCC_OFF_CTRL_A, {TCC_COM_TOGGLE, 4'h0, TCC_LO_PC});
		wr(TCC_OFF_FLAG, 8'h07);
		wr(TCC_OFF_CTRL_B, {4'h0, 1'b1, TCC_CS_DIV1});
		repeat (30) @(posedge clk);
		wr(TCC_OFF_CTRL_B, 8'h08);
		rc(TCC_OFF_FLAG, 8'h03, "pc_flags");
		rd(TCC_OFF_COUNT, v, r);
		check("pc_cnt", {31'h0, v < 32'h06}, 32'h1);
		// count pin, both edges
		wr(TCC_OFF_CTRL_A, 8'h00);
		wr(TCC_OFF_COUNT, 8'h00);
		wr(TCC_OFF_CTRL_B, {5'h0, TCC_CS_EXT_RISE});
		u_tcc_pin_model.pulse(5);
		wr(TCC_OFF_CTRL_B, {5'h0, TCC_CS_EXT_FALL});
		u_tcc_pin_model.pulse(3);
		wr(TCC_OFF_CTRL_B, 8'h00);
		rc(TCC_OFF_COUNT, 8'h08, "ext");
		// internal prescaler taps over a fixed span
		for (int i = 0; i < 5; i++) begin
			wr(TCC_OFF_COUNT, 8'h00);
			wr(TCC_OFF_CTRL_B, {5'h0, 3'(i + 1)});
			repeat (1040) @(posedge clk);
			wr(TCC_OFF_CTRL_B, 8'h00);
			rd(TCC_OFF_COUNT, v, r);
			check("presc", {31'h0, v >= lo[i] && v <= hi[i]}, 32'h1);
		end
		report_and_stop();
	end

endmodule : tcc_timer_bench
